// >>> sttl_frame_buf.sv
`default_nettype none

// One frame of slot words, one write and one read port.
module sttl_frame_buf #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 64,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } sttl_fb_state_t;

    localparam sttl_fb_state_t FB_RESET = {DEPTH{INIT}};

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_params
        $error("sttl_frame_buf: DEPTH must be at least 2 and WIDTH at least 1");
    end

    sttl_fb_state_t st_reg;
    sttl_fb_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (we_i) begin
            st_next.mem[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_reg <= FB_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.mem[raddr_i];

endmodule : sttl_frame_buf

`default_nettype wire

// >>> sttl_peer.sv
`default_nettype none

// ----------------------------------------------------------------
// Peripheral on the TDM pins
// ----------------------------------------------------------------
// Sends a fresh random frame each time and records what comes back.
module sttl_peer #(
    parameter int CH = 2
) (
    input wire logic bclk_i,
    input wire logic out0_i,
    input wire logic out1_i,
    output logic fsync_o,
    output logic in0_o,
    output logic in1_o,
    output logic frame_o,
    output logic [CH*32-1:0] prev0_o,
    output logic [CH*32-1:0] prev1_o,
    output logic [CH*32-1:0] obs0_o,
    output logic [CH*32-1:0] obs1_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = CH * 32;
    int pos = 0;
    int np;
    int q;
    logic [N-1:0] cur0 = '0;
    logic [N-1:0] cur1 = '0;
    logic [N-1:0] done0 = '0;
    logic [N-1:0] done1 = '0;
    logic [N-1:0] acc0 = '0;
    logic [N-1:0] acc1 = '0;
    logic [N-1:0] n0;
    logic [N-1:0] n1;

    initial begin
        {fsync_o, in0_o, in1_o, frame_o} = 4'h0;
        {prev0_o, prev1_o, obs0_o, obs1_o} = '0;
    end

    always @(posedge bclk_i) begin
        np = (pos + 1) % N;
        n0 = cur0;
        n1 = cur1;
        if (np == 0) begin
            for (int i = 0; i < CH; i++) begin
                n0[i*32 +: 32] = $urandom;
                n1[i*32 +: 32] = $urandom;
            end
            done0 <= cur0;
            done1 <= cur1;
            prev0_o <= done0;
            prev1_o <= done1;
        end
        cur0 <= n0;
        cur1 <= n1;
        fsync_o <= (np == 0);
        in0_o <= n0[N-1-np];
        in1_o <= n1[N-1-np];
        // Outputs lag one bit, so this edge shows position pos-1
        q = (pos + N - 1) % N;
        acc0[N-1-q] <= out0_i;
        acc1[N-1-q] <= out1_i;
        frame_o <= 1'b0;
        if (q == N - 1) begin
            obs0_o <= {acc0[N-1:1], out0_i};
            obs1_o <= {acc1[N-1:1], out1_i};
            frame_o <= 1'b1;
        end
        pos <= np;
    end
endmodule : sttl_peer

`default_nettype wire

// >>> sttl_pkg.sv
// Function
// - Bus loopback samples serial_out0/1 as bus receive data instead of serial_in0/1.
// - Bus loopback ignores second receiver select and both buffer loopback bits.
// - Pattern transmit drives 0xB38F0E32 on both serial outputs instead of bus data.
// - The same 32-bit pattern fills every TDM channel, nibble 1011 first, 0010 last.
// - Bus-looped data is truncated or zero-filled to the narrower slot width.
// - Receive-to-buffer plus buffer-to-transmit drive the inputs out one frame later.
// - Buffer-to-transmit without receive-to-buffer repeats the last received frame.
// - Buffer-to-transmit before any receive-to-buffer emits the default pattern.
`default_nettype none

package sttl_pkg;

    // ----------------------------------------------------------------
    // Serial frame
    // ----------------------------------------------------------------
    localparam int SLOT_BITS = 32;
    localparam logic [31:0] TX_PATTERN = 32'hB38F_0E32;
    localparam int WIDTH_BASE = 8;
    localparam int WIDTH_STEP = 4;
    localparam int SIZE_W = 3;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int AVS_ADDR_W = 5;
    localparam logic [4:0] OFS_TEST_CTRL = 5'h00;
    localparam logic [4:0] OFS_PORT_CFG = 5'h04;
    localparam logic [4:0] OFS_SLOT_FMT = 5'h08;
    localparam logic [4:0] OFS_BUS_DATA_CTRL = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;

    // serial_test_control fields
    localparam int TC_PATTERN_TX = 0;
    localparam int TC_BUF_TO_TX = 1;
    localparam int TC_RX_TO_BUF = 2;
    localparam int TC_SECOND_RX = 3;
    localparam int TC_BUS_LOOP = 4;
    localparam int TC_W = 5;
    localparam logic [4:0] TC_RESET = 5'h00;

    // serial_port_config fields
    localparam int PC_TX0_EN = 0;
    localparam int PC_TX1_EN = 1;
    localparam int PC_RX0_EN = 4;
    localparam int PC_RX1_EN = 5;
    localparam logic [3:0] PC_RESET = 4'h0;

    // slot_format fields
    localparam int SF_DN_LSB = 0;
    localparam int SF_UP_LSB = 4;
    localparam logic [2:0] SF_RESET = 3'h0;

    localparam logic [7:0] BDC_RESET = 8'h00;

    // status fields
    localparam int ST_BUF_LOADED = 0;
    localparam int ST_FRAME_TGL = 1;

    // ----------------------------------------------------------------
    // Control vector carried into the link domain
    // ----------------------------------------------------------------
    localparam int CV_TX0 = 5;
    localparam int CV_TX1 = 6;
    localparam int CV_RX0 = 7;
    localparam int CV_RX1 = 8;
    localparam int CV_UP_LSB = 9;
    localparam int CV_DN_LSB = 12;
    localparam int CV_RSTN = 15;
    localparam int CV_W = 16;

endpackage : sttl_pkg

`default_nettype wire

// >>> sttl_serial_test.sv
`default_nettype none

module sttl_serial_test
    import sttl_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [AVS_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic bclk_i,
    input wire logic fsync_i,
    input wire logic serial_in0_i,
    input wire logic serial_in1_i,
    output logic serial_out0_o,
    output logic serial_out1_o,
    input wire logic [31:0] bus_tx0_word_i,
    input wire logic [31:0] bus_tx1_word_i,
    output logic [$clog2(CHANNELS)-1:0] bus_slot_o,
    output logic [31:0] bus_rx0_word_o,
    output logic [31:0] bus_rx1_word_o,
    output logic bus_rx_valid_o
);

    localparam int IW = $clog2(CHANNELS);
    localparam logic [IW-1:0] LAST_SLOT = IW'(CHANNELS - 1);

    if (CHANNELS < 2 || CHANNELS > 32) begin : g_bad_channels
        $error("sttl_serial_test: CHANNELS must lie in 2..32");
    end

    // ----------------------------------------------------------------
    // Register side state (mclk)
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [TC_W-1:0] test_ctrl;
        logic [3:0] port_cfg;
        logic [SIZE_W-1:0] up_size;
        logic [SIZE_W-1:0] dn_size;
        logic [7:0] bus_data_ctrl;
        logic [31:0] rdata;
        logic wait_req;
    } sttl_reg_state_t;

    localparam sttl_reg_state_t REG_RESET = '{
        test_ctrl: TC_RESET,
        port_cfg: PC_RESET,
        up_size: SF_RESET,
        dn_size: SF_RESET,
        bus_data_ctrl: BDC_RESET,
        rdata: 32'h0000_0000,
        wait_req: 1'b1
    };

    // ----------------------------------------------------------------
    // Link side state (bclk)
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] bit_cnt;
        logic [IW-1:0] slot;
        logic [31:0] ld0;
        logic [31:0] ld1;
        logic [31:0] sh0;
        logic [31:0] sh1;
        logic out0;
        logic out1;
        logic [31:0] rx0w;
        logic [31:0] rx1w;
        logic rx_valid;
        logic [IW-1:0] bus_slot;
        logic loaded;
        logic frame_tgl;
    } sttl_link_state_t;

    localparam sttl_link_state_t LINK_RESET = '0;

    sttl_reg_state_t rg_reg;
    sttl_reg_state_t rg_next;
    sttl_link_state_t lk_reg;
    sttl_link_state_t lk_next;

    logic [CV_W-1:0] ctrl_vec;
    logic [CV_W-1:0] lc;
    logic [1:0] stat_sync;
    logic link_rstn;
    logic [63:0] buf_rdata;
    logic buf_we;
    logic [63:0] buf_wdata;
    logic [4:0] pos_bit;
    logic [IW-1:0] pos_slot;
    logic busloop;
    logic pattern;
    logic sel_rx1;
    logic rx2buf;
    logic buf2tx;
    logic [31:0] loop_mask;

    function automatic logic [31:0] sttl_width_mask(input logic [2:0] up_code,
                                                    input logic [2:0] dn_code);
        logic [2:0] narrow;
        logic [5:0] bits;
        narrow = (up_code < dn_code) ? up_code : dn_code;
        bits = 6'(WIDTH_BASE + WIDTH_STEP * int'(narrow));
        if (bits > 6'(SLOT_BITS)) begin
            bits = 6'(SLOT_BITS);
        end
        sttl_width_mask = ~(32'hFFFF_FFFF >> bits);
    endfunction : sttl_width_mask

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    // First request cycle latches read data and drops waitrequest;
    // the write lands on the edge that sees waitrequest low.
    always_comb begin
        rg_next = rg_reg;
        rg_next.wait_req = 1'b1;
        if ((avs_read_i || avs_write_i) && rg_reg.wait_req) begin
            rg_next.wait_req = 1'b0;
            rg_next.rdata = 32'h0000_0000;
            if (avs_read_i) begin
                unique case (avs_address_i)
                    OFS_TEST_CTRL: rg_next.rdata[TC_W-1:0] = rg_reg.test_ctrl;
                    OFS_PORT_CFG: begin
                        rg_next.rdata[PC_TX0_EN] = rg_reg.port_cfg[0];
                        rg_next.rdata[PC_TX1_EN] = rg_reg.port_cfg[1];
                        rg_next.rdata[PC_RX0_EN] = rg_reg.port_cfg[2];
                        rg_next.rdata[PC_RX1_EN] = rg_reg.port_cfg[3];
                    end
                    OFS_SLOT_FMT: begin
                        rg_next.rdata[SF_DN_LSB +: SIZE_W] = rg_reg.dn_size;
                        rg_next.rdata[SF_UP_LSB +: SIZE_W] = rg_reg.up_size;
                    end
                    OFS_BUS_DATA_CTRL: rg_next.rdata[7:0] = rg_reg.bus_data_ctrl;
                    OFS_STATUS: begin
                        rg_next.rdata[ST_BUF_LOADED] = stat_sync[0];
                        rg_next.rdata[ST_FRAME_TGL] = stat_sync[1];
                    end
                    default: rg_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        if (avs_write_i && !rg_reg.wait_req && avs_byteenable_i[0]) begin
            unique case (avs_address_i)
                OFS_TEST_CTRL: rg_next.test_ctrl = avs_writedata_i[TC_W-1:0];
                OFS_PORT_CFG: begin
                    rg_next.port_cfg = {avs_writedata_i[PC_RX1_EN],
                                        avs_writedata_i[PC_RX0_EN],
                                        avs_writedata_i[PC_TX1_EN],
                                        avs_writedata_i[PC_TX0_EN]};
                end
                OFS_SLOT_FMT: begin
                    rg_next.dn_size = avs_writedata_i[SF_DN_LSB +: SIZE_W];
                    rg_next.up_size = avs_writedata_i[SF_UP_LSB +: SIZE_W];
                end
                OFS_BUS_DATA_CTRL: rg_next.bus_data_ctrl = avs_writedata_i[7:0];
                default: rg_next.bus_data_ctrl = rg_reg.bus_data_ctrl;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rg_reg <= REG_RESET;
        end else begin
            rg_reg <= rg_next;
        end
    end

    assign avs_readdata_o = rg_reg.rdata;
    assign avs_waitrequest_o = rg_reg.wait_req;

    // ----------------------------------------------------------------
    // Clock domain crossings
    // ----------------------------------------------------------------
    assign ctrl_vec = {rstn_i, rg_reg.dn_size, rg_reg.up_size, rg_reg.port_cfg[3],
                       rg_reg.port_cfg[2], rg_reg.port_cfg[1], rg_reg.port_cfg[0],
                       rg_reg.test_ctrl};

    sttl_sync #(
        .W(CV_W)
    ) u_ctrl_sync (
        .clk_i(bclk_i),
        .d_i(ctrl_vec),
        .q_o(lc)
    );

    sttl_sync #(
        .W(2)
    ) u_stat_sync (
        .clk_i(mclk_i),
        .d_i({lk_reg.frame_tgl, lk_reg.loaded}),
        .q_o(stat_sync)
    );

    assign link_rstn = lc[CV_RSTN];

    // ----------------------------------------------------------------
    // Transmit frame buffer
    // ----------------------------------------------------------------
    sttl_frame_buf #(
        .DEPTH(CHANNELS),
        .WIDTH(64),
        .INIT({TX_PATTERN, TX_PATTERN})
    ) u_frame_buf (
        .clk_i(bclk_i),
        .rstn_i(link_rstn),
        .we_i(buf_we),
        .waddr_i(pos_slot),
        .wdata_i(buf_wdata),
        .raddr_i(pos_slot),
        .rdata_o(buf_rdata)
    );

    // ----------------------------------------------------------------
    // Serial link engine (bclk)
    // ----------------------------------------------------------------
    assign busloop = lc[TC_BUS_LOOP];
    assign pattern = lc[TC_PATTERN_TX];
    assign sel_rx1 = lc[TC_SECOND_RX] && !busloop;
    assign rx2buf = lc[TC_RX_TO_BUF] && !busloop;
    assign buf2tx = lc[TC_BUF_TO_TX] && !busloop;
    assign loop_mask = sttl_width_mask(lc[CV_UP_LSB +: SIZE_W], lc[CV_DN_LSB +: SIZE_W]);

    always_comb begin
        logic load;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] cur0;
        logic [31:0] cur1;
        logic in0;
        logic in1;
        logic [31:0] word0;
        logic [31:0] word1;
        lk_next = lk_reg;
        load = 1'b0;
        w0 = bus_tx0_word_i;
        w1 = bus_tx1_word_i;
        cur0 = 32'h0000_0000;
        cur1 = 32'h0000_0000;
        in0 = 1'b0;
        in1 = 1'b0;
        word0 = 32'h0000_0000;
        word1 = 32'h0000_0000;
        buf_we = 1'b0;
        lk_next.rx_valid = 1'b0;
        if (fsync_i) begin
            pos_bit = 5'h00;
            pos_slot = '0;
            lk_next.frame_tgl = !lk_reg.frame_tgl;
        end else if (lk_reg.bit_cnt == 5'h1F) begin
            pos_bit = 5'h00;
            pos_slot = (lk_reg.slot == LAST_SLOT) ? '0 : IW'(lk_reg.slot + 1'b1);
        end else begin
            pos_bit = 5'(lk_reg.bit_cnt + 5'h01);
            pos_slot = lk_reg.slot;
        end
        lk_next.bit_cnt = pos_bit;
        lk_next.slot = pos_slot;
        load = (pos_bit == 5'h00);
        if (pattern) begin
            w0 = TX_PATTERN;
            w1 = TX_PATTERN;
        end else if (buf2tx) begin
            w0 = buf_rdata[31:0];
            w1 = buf_rdata[63:32];
        end
        if (load) begin
            lk_next.ld0 = w0;
            lk_next.ld1 = w1;
            lk_next.bus_slot = (pos_slot == LAST_SLOT) ? '0 : IW'(pos_slot + 1'b1);
        end
        cur0 = load ? w0 : lk_reg.ld0;
        cur1 = load ? w1 : lk_reg.ld1;
        lk_next.out0 = lc[CV_TX0] && cur0[5'h1F - pos_bit];
        lk_next.out1 = lc[CV_TX1] && cur1[5'h1F - pos_bit];
        // Loopback samples the bit being driven on each output
        in0 = busloop ? lk_next.out0 : (sel_rx1 ? serial_in1_i : serial_in0_i);
        in1 = busloop ? lk_next.out1 : serial_in1_i;
        in0 = in0 && lc[CV_RX0];
        in1 = in1 && lc[CV_RX1];
        lk_next.sh0 = {lk_reg.sh0[30:0], in0};
        lk_next.sh1 = {lk_reg.sh1[30:0], in1};
        word0 = lk_next.sh0;
        word1 = lk_next.sh1;
        if (busloop) begin
            word0 = word0 & loop_mask;
            word1 = word1 & loop_mask;
        end
        buf_wdata = {word1, word0};
        if (pos_bit == 5'h1F) begin
            lk_next.rx0w = word0;
            lk_next.rx1w = word1;
            lk_next.rx_valid = 1'b1;
            buf_we = rx2buf;
            if (rx2buf) begin
                lk_next.loaded = 1'b1;
            end
        end
    end

    always_ff @(posedge bclk_i) begin
        if (!link_rstn) begin
            lk_reg <= LINK_RESET;
        end else begin
            lk_reg <= lk_next;
        end
    end

    assign serial_out0_o = lk_reg.out0;
    assign serial_out1_o = lk_reg.out1;
    assign bus_slot_o = lk_reg.bus_slot;
    assign bus_rx0_word_o = lk_reg.rx0w;
    assign bus_rx1_word_o = lk_reg.rx1w;
    assign bus_rx_valid_o = lk_reg.rx_valid;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_pattern_out0: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        (pos_bit == 5'h00 && pattern && lc[CV_TX0]) |=> serial_out0_o == TX_PATTERN[31]
    ) else $error("pattern not driven on serial_out0");

    a_pattern_out1: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        (pos_bit == 5'h00 && pattern && lc[CV_TX1])
        |=> (lk_reg.ld1 == TX_PATTERN && serial_out1_o == TX_PATTERN[31])
    ) else $error("pattern not loaded for serial_out1");

    a_loop_word_back: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        (pos_bit == 5'h1F && busloop && $past(busloop, 31) && lc[CV_TX0] && lc[CV_RX0]
         && lk_reg.bit_cnt == 5'h1E)
        |=> bus_rx0_word_o == (lk_reg.ld0 & $past(loop_mask))
    ) else $error("looped word differs from driven word");

    a_loop_no_buffer: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        busloop |-> !buf_we
    ) else $error("buffer written during bus loopback");

    a_width_zero_fill: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        (bus_rx_valid_o && $past(busloop))
        |-> ((bus_rx0_word_o | bus_rx1_word_o) & ~$past(loop_mask)) == 32'h0000_0000
    ) else $error("looped word not cut to narrower slot");

    a_buffer_to_out: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        (pos_bit == 5'h00 && buf2tx && !pattern && lc[CV_TX0])
        |=> serial_out0_o == $past(buf_rdata[31])
    ) else $error("buffered word not driven on serial_out0");

    a_hold_last_frame: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        !rx2buf |-> !buf_we
    ) else $error("buffer overwritten while receive loopback off");

    a_default_pattern: assert property (@(posedge bclk_i) disable iff (!link_rstn)
        (pos_bit == 5'h00 && buf2tx && !pattern && !lk_reg.loaded && lc[CV_TX1])
        |=> (lk_reg.ld1 == TX_PATTERN && serial_out1_o == TX_PATTERN[31])
    ) else $error("default pattern missing before first receive");

    a_avs_one_wait: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o ##1
        avs_waitrequest_o
    ) else $error("waitrequest answer not one cycle");

endmodule : sttl_serial_test

`default_nettype wire

// >>> sttl_sync.sv
`default_nettype none

// Two-stage level synchroniser; only the second stage is visible.
module sttl_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sttl_sync_state_t;

    sttl_sync_state_t st_reg;
    sttl_sync_state_t st_next;

    always_comb begin
        st_next.meta = d_i;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    assign q_o = st_reg.stable;

endmodule : sttl_sync

`default_nettype wire

// >>> tb_top.sv
`default_nettype none

module tb_top;
    import sttl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CH = 2;
    localparam int N = CH * 32;
    logic mclk, rstn, bclk, rd, wr, wait_rq, fs, in0, in1, out0, out1, rxv, frame;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, bw0, bw1, rx0, rx1;
    logic [3:0] be;
    logic [N-1:0] prev0, prev1, obs0, obs1;
    int errors = 0;
    int compares = 0;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        bclk = 1'b0;
        #7;
        forever #40 bclk = ~bclk;
    end

    sttl_serial_test #(.CHANNELS(CH)) u_dut (
        .mclk_i(mclk), .rstn_i(rstn), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .bclk_i(bclk),
        .fsync_i(fs), .serial_in0_i(in0), .serial_in1_i(in1), .serial_out0_o(out0),
        .serial_out1_o(out1), .bus_tx0_word_i(bw0), .bus_tx1_word_i(bw1), .bus_slot_o(),
        .bus_rx0_word_o(rx0), .bus_rx1_word_o(rx1), .bus_rx_valid_o(rxv)
    );
    sttl_peer #(.CH(CH)) u_peer (
        .bclk_i(bclk), .out0_i(out0), .out1_i(out1), .fsync_o(fs), .in0_o(in0),
        .in1_o(in1), .frame_o(frame), .prev0_o(prev0), .prev1_o(prev1),
        .obs0_o(obs0), .obs1_o(obs1)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge mclk);
        end while (wait_rq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : av

    task automatic wait_bclk(input logic which);
        do begin
            @(posedge bclk);
        end while ((which ? rxv : frame) !== 1'b1);
    endtask : wait_bclk

    function automatic logic [31:0] trunc(input logic [31:0] w, input int u, input int d);
        return w & ~(32'hFFFF_FFFF >> (8 + 4 * (u < d ? u : d)));
    endfunction : trunc

    initial begin
        #1ms;
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        int u, d;
        logic [31:0] r, w0, w1;
        logic [63:0] pat, a;
        r = $urandom(32'hA6AE80FF);
        pat = {CH{TX_PATTERN}};
        {rstn, rd, wr} = 3'h0;
        addr = 5'h00;
        wdata = 32'h0;
        be = 4'hF;
        bw0 = $urandom;
        bw1 = $urandom;
        // Reset must also be seen by the link domain
        repeat (3) @(posedge mclk);
        repeat (4) @(posedge bclk);
        @(posedge mclk);
        rstn <= 1'b1;
        av(1'b0, OFS_TEST_CTRL, 32'h0, 4'hF, r);
        check({32'h0, r}, 64'h0, "test ctrl reset");
        av(1'b0, 5'h14, 32'h0, 4'hF, r);
        check({32'h0, r}, 64'h0, "unmapped read");
        av(1'b1, OFS_PORT_CFG, 32'h33, 4'hF, r);
        av(1'b1, OFS_BUS_DATA_CTRL, 32'h00, 4'hF, r);
        av(1'b1, OFS_TEST_CTRL, 32'h1F, 4'h0, r);
        av(1'b0, OFS_TEST_CTRL, 32'h0, 4'hF, r);
        check({32'h0, r}, 64'h0, "masked write");
        av(1'b1, OFS_TEST_CTRL, 32'h02, 4'hF, r);
        repeat (3) wait_bclk(1'b0);
        check(obs0, pat, "preset buffer line 0");
        check(obs1, pat, "preset buffer line 1");
        av(1'b1, OFS_TEST_CTRL, 32'h01, 4'hF, r);
        repeat (3) wait_bclk(1'b0);
        check(obs0, pat, "pattern line 0");
        check(obs1, pat, "pattern line 1");
        check({60'h0, obs0[N-1 -: 4]}, 64'hB, "top nibble");
        check({60'h0, obs1[3:0]}, 64'h2, "bottom nibble");
        av(1'b1, OFS_TEST_CTRL, 32'h06, 4'hF, r);
        repeat (3) wait_bclk(1'b0);
        for (int k = 0; k < 4; k++) begin
            wait_bclk(1'b0);
            check(obs0, prev0, "frame delay line 0");
            check(obs1, prev1, "frame delay line 1");
        end
        av(1'b0, OFS_STATUS, 32'h0, 4'hF, r);
        check({63'h0, r[ST_BUF_LOADED]}, 64'h1, "buffer loaded");
        av(1'b1, OFS_TEST_CTRL, 32'h02, 4'hF, r);
        repeat (3) wait_bclk(1'b0);
        a = obs0;
        check({63'h0, a === pat}, 64'h0, "held frame is data");
        repeat (2) begin
            wait_bclk(1'b0);
            check(obs0, a, "held frame repeats");
        end
        for (int k = 0; k < 5; k++) begin
            u = (k == 1) ? 0 : ((k == 0) ? 6 : $urandom_range(6, 0));
            d = (k < 2) ? 6 : $urandom_range(6, 0);
            w0 = $urandom;
            w1 = $urandom;
            @(posedge bclk);
            bw0 <= w0;
            bw1 <= w1;
            av(1'b1, OFS_SLOT_FMT, 32'(u * 16 + d), 4'hF, r);
            av(1'b1, OFS_TEST_CTRL, 32'h1E, 4'hF, r);
            repeat (3) wait_bclk(1'b0);
            check(obs0, {CH{w0}}, "bus words line 0");
            check(obs1, {CH{w1}}, "bus words line 1");
            wait_bclk(1'b1);
            check({32'h0, rx0}, {32'h0, trunc(w0, u, d)}, "loop line 0");
            check({32'h0, rx1}, {32'h0, trunc(w1, u, d)}, "loop line 1");
        end
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
